//--- rtl/nfh_pkg.sv
// Package of constants for the NAND flash host pin controller
package nfh_pkg;
    // Array geometry
    localparam int PAGES_PER_BLOCK     = 32;
    localparam int HALF_PAGE_BYTES     = 256;
    localparam int SPARE_BYTES         = 16;
    localparam int MAIN_WORDS          = 256;
    localparam int SPARE_WORDS         = 8;
    localparam int MAX_BLOCKS          = 4096;
    localparam int MIN_VALID_BLOCKS    = 4016;
    // Timing
    localparam int CLOCK_MHZ           = 200;
    localparam int RECOVERY_US         = 10;
    localparam int RECOVERY_CYCLES     = RECOVERY_US * CLOCK_MHZ;
    localparam int STROBE_CYCLES       = 4;
    // Operation kinds requested by the user side
    typedef enum logic [1:0] {
        NFH_OP_CMD  = 2'b00,
        NFH_OP_ADDR = 2'b01,
        NFH_OP_WR   = 2'b10,
        NFH_OP_RD   = 2'b11
    } nfh_op_t;
    // Sequencer states
    typedef enum logic [2:0] {
        NFH_ST_RECOVER = 3'b000,
        NFH_ST_IDLE    = 3'b001,
        NFH_ST_WLOW    = 3'b010,
        NFH_ST_WHIGH   = 3'b011,
        NFH_ST_RLOW    = 3'b100,
        NFH_ST_RHIGH   = 3'b101
    } nfh_state_t;
endpackage

//--- rtl/nfh_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module nfh_sync (
    input  wire logic i_clock,
    input  wire logic i_rst_n,
    input  wire logic i_async,
    output logic      o_level
);
    logic [2:0] stage_reg;
    logic [2:0] stage_next;
    logic       level_reg;
    logic       level_next;

    // Shift chain; level changes once stages two and three agree
    always_comb begin
        stage_next = {stage_reg[1:0], i_async};
        level_next = level_reg;
        if (stage_reg[1] == stage_reg[2]) begin
            level_next = stage_reg[2];
        end
    end

    // Registers, read as busy after reset until the line is seen high
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stage_reg <= 3'h0;
            level_reg <= 1'b0;
        end else begin
            stage_reg <= stage_next;
            level_reg <= level_next;
        end
    end

    assign o_level = level_reg;
endmodule

//--- rtl/nfh_ctrl.sv
// Host-side pin sequencer driving a small-page NAND flash
// ====================================================================
`timescale 1ns/1ps
module nfh_ctrl
    import nfh_pkg::*;
#(
    parameter int WIDE          = 0,
    parameter int RECOVER_COUNT = nfh_pkg::RECOVERY_CYCLES,
    parameter int STROBE_COUNT  = nfh_pkg::STROBE_CYCLES,
    parameter bit CS_IGNORE     = 1'b0
) (
    input  wire logic              i_clock,
    input  wire logic              i_reset_n,
    // User request side
    input  wire logic              i_req_valid,
    input  wire nfh_pkg::nfh_op_t  i_req_op,
    input  wire logic [15:0]       i_req_data,
    input  wire logic              i_req_last,
    input  wire logic              i_wp_enable,
    output logic                   o_req_ready,
    output logic                   o_rsp_valid,
    output logic [15:0]            o_rsp_data,
    output logic                   o_ready_seen,
    // Device pins
    output logic                   o_cs_n,
    output logic                   o_cmd_strobe_in,
    output logic                   o_addr_strobe_in,
    output logic                   o_wr_n,
    output logic                   o_rd_n,
    output logic                   o_wp_n,
    output logic [7:0]             o_low_byte_lane,
    output logic [7:0]             o_low_byte_lane_oe_n,
    input  wire logic [7:0]        i_low_byte_lane,
    output logic [7:0]             o_high_byte_lane,
    output logic [7:0]             o_high_byte_lane_oe_n,
    input  wire logic [7:0]        i_high_byte_lane,
    input  wire logic              i_busy_flag_od
);
    import nfh_pkg::*;

    localparam int CW = $clog2(RECOVER_COUNT + 1);

    // ================================================================
    // Reset release and busy line synchroniser
    logic [1:0] rst_sync_reg;
    logic       rst_n;
    logic       busy_n_level;

    // Two-stage reset release
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // Shared open-drain line, low means one or more busy
    nfh_sync u_busy_sync (
        .i_clock (i_clock),
        .i_rst_n (rst_n),
        .i_async (i_busy_flag_od),
        .o_level (busy_n_level)
    );

    // ================================================================
    // Sequencer state
    nfh_state_t  state_reg,   state_next;
    logic [CW-1:0] cnt_reg,   cnt_next;
    nfh_op_t     op_reg,      op_next;
    logic [15:0] data_reg,    data_next;
    logic        last_reg,    last_next;
    logic        cs_n_reg,    cs_n_next;
    logic        cle_reg,     cle_next;
    logic        ale_reg,     ale_next;
    logic        wr_n_reg,    wr_n_next;
    logic        rd_n_reg,    rd_n_next;
    logic        wp_n_reg,    wp_n_next;
    logic        drive_reg,   drive_next;
    logic        rdy_reg,     rdy_next;
    logic        rsp_v_reg,   rsp_v_next;
    logic [15:0] rsp_d_reg,   rsp_d_next;
    logic        seen_reg,    seen_next;
    logic        in_read_reg, in_read_next;

    // Next-state logic for the pin sequencer
    always_comb begin
        state_next   = state_reg;
        cnt_next     = cnt_reg;
        op_next      = op_reg;
        data_next    = data_reg;
        last_next    = last_reg;
        cs_n_next    = cs_n_reg;
        cle_next     = cle_reg;
        ale_next     = ale_reg;
        wr_n_next    = wr_n_reg;
        rd_n_next    = rd_n_reg;
        wp_n_next    = wp_n_reg;
        drive_next   = drive_reg;
        rdy_next     = 1'b0;
        rsp_v_next   = 1'b0;
        rsp_d_next   = rsp_d_reg;
        seen_next    = busy_n_level;
        in_read_next = in_read_reg;
        case (state_reg)
            NFH_ST_RECOVER: begin
                // Hold write strobe high, protect low, no commands
                wr_n_next = 1'b1;
                wp_n_next = 1'b0;
                if (cnt_reg == CW'(RECOVER_COUNT)) begin
                    if (busy_n_level) begin
                        state_next = NFH_ST_IDLE;
                        rdy_next   = 1'b1;
                    end
                end else begin
                    cnt_next = cnt_reg + CW'(1);
                end
            end
            NFH_ST_IDLE: begin
                wp_n_next = i_wp_enable ? 1'b0 : 1'b1;
                // Select follows last op unless a read busy needs it held
                cs_n_next = last_reg;
                if (in_read_reg && !busy_n_level && !CS_IGNORE) begin
                    cs_n_next = 1'b0;
                end
                if (o_req_ready && i_req_valid) begin
                    op_next    = i_req_op;
                    last_next  = i_req_last;
                    // Commands and addresses use the low lane only
                    data_next  = (i_req_op == NFH_OP_WR && WIDE != 0)
                               ? i_req_data
                               : {8'h00, i_req_data[7:0]};
                    cs_n_next  = 1'b0;
                    cle_next   = (i_req_op == NFH_OP_CMD);
                    ale_next   = (i_req_op == NFH_OP_ADDR);
                    cnt_next   = '0;
                    if (i_req_op == NFH_OP_RD) begin
                        drive_next = 1'b0;
                        rd_n_next  = 1'b0;
                        state_next = NFH_ST_RLOW;
                    end else begin
                        drive_next = 1'b1;
                        wr_n_next  = 1'b0;
                        state_next = NFH_ST_WLOW;
                    end
                end else begin
                    rdy_next = 1'b1;
                end
            end
            NFH_ST_WLOW: begin
                if (cnt_reg == CW'(STROBE_COUNT - 1)) begin
                    wr_n_next  = 1'b1; // Rising edge latches
                    cnt_next   = '0;
                    state_next = NFH_ST_WHIGH;
                end else begin
                    cnt_next = cnt_reg + CW'(1);
                end
            end
            NFH_ST_WHIGH: begin
                if (cnt_reg == CW'(STROBE_COUNT - 1)) begin
                    cle_next     = 1'b0;
                    ale_next     = 1'b0;
                    drive_next   = 1'b0;
                    // Address may start a read busy; data or command ends it
                    in_read_next = (op_reg == NFH_OP_ADDR);
                    cs_n_next    = last_reg;
                    rdy_next     = 1'b1;
                    state_next   = NFH_ST_IDLE;
                end else begin
                    cnt_next = cnt_reg + CW'(1);
                end
            end
            NFH_ST_RLOW: begin
                if (cnt_reg == CW'(STROBE_COUNT - 1)) begin
                    // Sample just before the rise, data is valid here
                    rsp_d_next = (WIDE != 0)
                               ? {i_high_byte_lane, i_low_byte_lane}
                               : {8'h00, i_low_byte_lane};
                    rsp_v_next = 1'b1;
                    rd_n_next  = 1'b1;
                    cnt_next   = '0;
                    state_next = NFH_ST_RHIGH;
                end else begin
                    cnt_next = cnt_reg + CW'(1);
                end
            end
            NFH_ST_RHIGH: begin
                if (cnt_reg == CW'(STROBE_COUNT - 1)) begin
                    in_read_next = 1'b0;
                    cs_n_next    = last_reg;
                    rdy_next     = 1'b1;
                    state_next   = NFH_ST_IDLE;
                end else begin
                    cnt_next = cnt_reg + CW'(1);
                end
            end
            default: begin
                state_next = NFH_ST_RECOVER;
                cnt_next   = '0;
            end
        endcase
    end

    // Register bank for the sequencer
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg   <= NFH_ST_RECOVER;
            cnt_reg     <= '0;
            op_reg      <= NFH_OP_CMD;
            data_reg    <= 16'h0000;
            last_reg    <= 1'b1;
            cs_n_reg    <= 1'b1;
            cle_reg     <= 1'b0;
            ale_reg     <= 1'b0;
            wr_n_reg    <= 1'b1;
            rd_n_reg    <= 1'b1;
            wp_n_reg    <= 1'b0;
            drive_reg   <= 1'b0;
            rdy_reg     <= 1'b0;
            rsp_v_reg   <= 1'b0;
            rsp_d_reg   <= 16'h0000;
            seen_reg    <= 1'b0;
            in_read_reg <= 1'b0;
        end else begin
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            op_reg      <= op_next;
            data_reg    <= data_next;
            last_reg    <= last_next;
            cs_n_reg    <= cs_n_next;
            cle_reg     <= cle_next;
            ale_reg     <= ale_next;
            wr_n_reg    <= wr_n_next;
            rd_n_reg    <= rd_n_next;
            wp_n_reg    <= wp_n_next;
            drive_reg   <= drive_next;
            rdy_reg     <= rdy_next;
            rsp_v_reg   <= rsp_v_next;
            rsp_d_reg   <= rsp_d_next;
            seen_reg    <= seen_next;
            in_read_reg <= in_read_next;
        end
    end

    // ================================================================
    // Outputs straight from flip-flops
    assign o_req_ready      = rdy_reg;
    assign o_rsp_valid      = rsp_v_reg;
    assign o_rsp_data       = rsp_d_reg;
    assign o_ready_seen     = seen_reg;
    assign o_cs_n           = cs_n_reg;
    assign o_cmd_strobe_in  = cle_reg;
    assign o_addr_strobe_in = ale_reg;
    assign o_wr_n           = wr_n_reg;
    assign o_rd_n           = rd_n_reg;
    assign o_wp_n           = wp_n_reg;
    assign o_low_byte_lane  = data_reg[7:0];
    assign o_high_byte_lane = data_reg[15:8];
    // Enables low while driving; high lane only for wide data
    assign o_low_byte_lane_oe_n  = {8{~drive_reg}};
    assign o_high_byte_lane_oe_n = {8{~(drive_reg & (WIDE != 0)
                                        & (op_reg == NFH_OP_WR))}};
endmodule

//--- dv/nfh_ctrl_monitor.sv
// Checker of host pin sequencing for the NAND flash controller
`timescale 1ns/1ps
module nfh_ctrl_monitor #(
    parameter int RECOVER_COUNT = 8
) (
    input wire logic       i_clock,
    input wire logic       i_reset_n,
    input wire logic       i_busy_flag_od,
    input wire logic       o_req_ready,
    input wire logic       o_rsp_valid,
    input wire logic       o_ready_seen,
    input wire logic       o_cs_n,
    input wire logic       o_cmd_strobe_in,
    input wire logic       o_addr_strobe_in,
    input wire logic       o_wr_n,
    input wire logic       o_rd_n,
    input wire logic [7:0] o_low_byte_lane_oe_n,
    input wire logic [7:0] o_high_byte_lane_oe_n
);
    logic [15:0] up_cnt_reg;
    logic        started_reg;
    // ==========================================================
    // Cycles since reset release, and first ready seen
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            up_cnt_reg  <= 16'h0000;
            started_reg <= 1'b0;
        end else begin
            if (up_cnt_reg != 16'hFFFF)
                up_cnt_reg <= up_cnt_reg + 16'h0001;
            if (o_req_ready)
                started_reg <= 1'b1;
        end
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    recov_wait_a: assert property (
        o_req_ready |-> up_cnt_reg >= RECOVER_COUNT)
        else $error("request accepted inside recovery");
    recov_wr_a: assert property (
        !started_reg |-> o_wr_n) else $error("write strobe low in recovery");
    busy_seen_a: assert property (
        !i_busy_flag_od [*6] |-> !o_ready_seen)
        else $error("busy line low but ready reported");
    wr_pulse_a: assert property (
        $fell(o_wr_n) |-> !o_wr_n [*4] ##1 o_wr_n)
        else $error("write strobe pulse length wrong");
    cmd_hold_a: assert property (
        $rose(o_wr_n) && $past(o_cmd_strobe_in) |-> o_cmd_strobe_in)
        else $error("command strobe dropped at latch edge");
    addr_hold_a: assert property (
        $rose(o_wr_n) && $past(o_addr_strobe_in) |-> o_addr_strobe_in)
        else $error("address strobe dropped at latch edge");
    wr_sel_a: assert property (
        !o_wr_n |-> !o_cs_n && o_rd_n && o_low_byte_lane_oe_n == 8'h00)
        else $error("write without select or lane drive");
    rd_float_a: assert property (
        !o_rd_n |-> !o_cs_n && o_wr_n && !o_cmd_strobe_in
            && !o_addr_strobe_in && o_low_byte_lane_oe_n == 8'hFF)
        else $error("read phase with bad pin state");
    rd_word_a: assert property (
        $fell(o_rd_n) |-> ##4 (o_rsp_valid && o_rd_n))
        else $error("read word not returned on time");
    hi_lane_a: assert property (
        o_cmd_strobe_in || o_addr_strobe_in |-> o_high_byte_lane_oe_n == 8'hFF)
        else $error("high lane driven with command or address");
    cov_cmd_c: cover property ($rose(o_wr_n) && o_cmd_strobe_in);
    cov_rd_c: cover property (o_rsp_valid);
    cov_busy_c: cover property ($fell(o_ready_seen));
endmodule
bind nfh_ctrl nfh_ctrl_monitor #(.RECOVER_COUNT(RECOVER_COUNT)) mon_u (
    .i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_busy_flag_od(i_busy_flag_od), .o_req_ready(o_req_ready),
    .o_rsp_valid(o_rsp_valid), .o_ready_seen(o_ready_seen),
    .o_cs_n(o_cs_n), .o_cmd_strobe_in(o_cmd_strobe_in),
    .o_addr_strobe_in(o_addr_strobe_in), .o_wr_n(o_wr_n), .o_rd_n(o_rd_n),
    .o_low_byte_lane_oe_n(o_low_byte_lane_oe_n),
    .o_high_byte_lane_oe_n(o_high_byte_lane_oe_n));

//--- dv/nfh_dev_model.sv
// Behavioural byte-wide small-page NAND flash device
`timescale 1ns/1ps
module nfh_dev_model #(
    parameter int         RECOV_CYCLES = 20,
    parameter int         READ_CYCLES  = 30,
    parameter int         PROG_CYCLES  = 40,
    parameter logic [7:0] READ_CODE    = 8'h5A, // Arbitrary opcode
    parameter logic [7:0] PROG_CODE    = 8'hA5, // Arbitrary opcode
    parameter bit         CS_IGNORE    = 1'b0
) (
    input  wire logic       i_clock,
    input  wire logic       i_power_ok,
    input  wire logic       i_cs_n,
    input  wire logic       i_cmd_strobe_in,
    input  wire logic       i_addr_strobe_in,
    input  wire logic       i_wr_n,
    input  wire logic       i_rd_n,
    input  wire logic       i_wp_n,
    input  wire logic [7:0] i_low_byte_lane,
    output logic      [7:0] o_low_byte_lane,
    output logic            o_low_byte_lane_oe_n,
    output logic            o_busy_flag_oe_n
);
    import nfh_pkg::*;
    localparam int PAGE_LOCS = 2 * HALF_PAGE_BYTES + SPARE_BYTES;
    // Word page of MAIN_WORDS plus SPARE_WORDS fits the same pointer
    logic [7:0] mem [0:PAGE_LOCS-1]; // Halves and spare
    logic [9:0] col;
    int         busy_cnt;
    logic       rd_busy, rd_pend, wr_q, rd_q;
    // ==========================================================
    // Open-drain busy, pulled low while counting
    assign o_busy_flag_oe_n = (busy_cnt == 0);
    // Drive only when selected and reading
    assign o_low_byte_lane_oe_n = !(i_power_ok && !i_cs_n && i_wr_n
        && !i_rd_n && !i_cmd_strobe_in && !i_addr_strobe_in);
    // Strobes sampled and edge-detected on the clock
    always @(posedge i_clock) begin
        wr_q <= i_wr_n;
        rd_q <= i_rd_n;
        if (!i_power_ok) begin
            busy_cnt <= RECOV_CYCLES;
            rd_pend  <= 1'b0;
            rd_busy  <= 1'b0;
        end else if (busy_cnt != 0) begin
            // Read busy aborts on deselect unless the ignore option is set
            busy_cnt <= (rd_busy && i_cs_n && !CS_IGNORE)
                ? 0 : busy_cnt - 1;
        end else if (!i_cs_n && !wr_q && i_wr_n) begin
            if (i_cmd_strobe_in) begin
                rd_pend <= (i_low_byte_lane == READ_CODE);
                rd_busy <= 1'b0;
                if (i_wp_n && i_low_byte_lane == PROG_CODE)
                    busy_cnt <= PROG_CYCLES;
            end else if (i_addr_strobe_in) begin
                col <= {2'b00, i_low_byte_lane};
                rd_busy <= rd_pend;
                rd_pend <= 1'b0;
                if (rd_pend)
                    busy_cnt <= READ_CYCLES;
            end else begin
                mem[col] <= i_low_byte_lane;
                col <= col + 10'h001;
            end
        end else if (!i_cs_n && rd_q && !i_rd_n) begin
            o_low_byte_lane <= mem[col];
            col <= col + 10'h001;
        end
    end
endmodule

//--- dv/tb_nfh_ctrl.sv
// Testbench of the NAND flash host pin controller
`timescale 1ns/1ps
module tb_nfh_ctrl;
    import nfh_pkg::*;
    localparam logic [7:0] RD_C = 8'h5A, PG_C = 8'hA5, LD_C = 8'h80;
    logic        clk, rst_n, pwr_ok, req_valid, req_last, wp_en;
    logic        req_ready, rsp_valid, ready_seen, cs_n, cmd_s, addr_s;
    logic        wr_n, rd_n, wp_n, dev_oe_n, busy_oe_n;
    nfh_op_t     req_op;
    logic [15:0] req_data, rsp_data;
    logic [7:0]  lo_out, lo_oe_n, lane, dev_out, lane_q = 8'h00;
    logic [31:0] seed = 32'd15596;
    int          err_total = 0, n_checks = 0;
    // ==========================================================
    // Lane resolution: a floating lane toggles every cycle
    always_comb for (int i = 0; i < 8; i++)
        lane[i] = !lo_oe_n[i] ? lo_out[i] : !dev_oe_n ? dev_out[i] : ~lane_q[i];
    always @(posedge clk) lane_q <= lane;
    always #2.5 clk = ~clk;
    nfh_ctrl #(.WIDE(0), .RECOVER_COUNT(8), .STROBE_COUNT(4),
        .CS_IGNORE(1'b0)) dut_u (.i_clock(clk), .i_reset_n(rst_n),
        .i_req_valid(req_valid), .i_req_op(req_op), .i_req_data(req_data),
        .i_req_last(req_last), .i_wp_enable(wp_en), .o_req_ready(req_ready),
        .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data),
        .o_ready_seen(ready_seen), .o_cs_n(cs_n), .o_cmd_strobe_in(cmd_s),
        .o_addr_strobe_in(addr_s), .o_wr_n(wr_n), .o_rd_n(rd_n),
        .o_wp_n(wp_n), .o_low_byte_lane(lo_out), .o_low_byte_lane_oe_n(lo_oe_n),
        .i_low_byte_lane(lane), .o_high_byte_lane(),
        .o_high_byte_lane_oe_n(), .i_high_byte_lane(8'h00),
        .i_busy_flag_od(busy_oe_n));
    nfh_dev_model #(.READ_CODE(RD_C), .PROG_CODE(PG_C)) dev_u (
        .i_clock(clk), .i_power_ok(pwr_ok), .i_cs_n(cs_n),
        .i_cmd_strobe_in(cmd_s), .i_addr_strobe_in(addr_s), .i_wr_n(wr_n),
        .i_rd_n(rd_n), .i_wp_n(wp_n), .i_low_byte_lane(lane),
        .o_low_byte_lane(dev_out), .o_low_byte_lane_oe_n(dev_oe_n),
        .o_busy_flag_oe_n(busy_oe_n));
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // One request, held until taken; read data returned in q
    task automatic do_op(input nfh_op_t op, input logic [7:0] d,
                         input logic last, input logic wp,
                         output logic [15:0] q);
        int n;
        n = 0;
        @(posedge clk);
        #1;
        req_valid = 1'b1;
        req_op    = op;
        req_data  = {8'h00, d};
        req_last  = last;
        wp_en     = wp;
        @(negedge clk);
        while (req_ready !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        while (op == NFH_OP_RD && rsp_valid !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        q = rsp_data;
        if (n >= 200)
            check(16'hDEAD, 16'h0000);
    endtask
    task automatic wait_seen(input logic v, input int lim);
        repeat (lim) begin
            @(negedge clk);
            if (ready_seen === v) break;
        end
        check(ready_seen, v);
    endtask
    initial begin
        int r, i;
        logic [7:0] col;
        logic [15:0] q;
        logic [7:0] exp_b [0:5];
        {clk, rst_n, pwr_ok, req_valid, req_last, wp_en} = 6'b000001;
        req_op   = NFH_OP_CMD;
        req_data = 16'h0000;
        #21 pwr_ok = 1'b1;
        repeat (16) @(posedge clk);
        #1 rst_n = 1'b1;
        for (r = 0; r < 2; r++) begin
            if (r == 1) begin // Power cycle and reset in mid-run
                @(posedge clk);
                #1 {rst_n, pwr_ok} = 2'b00;
                repeat (4) @(posedge clk);
                #1 {rst_n, pwr_ok} = 2'b11;
                @(negedge clk);
                check(busy_oe_n, 1'b0);
                check(wp_n, 1'b0);
            end
            wait_seen(1'b1, 300);
            col = (r == 0) ? rnd() : 8'hFE; // Crosses into second half
            do_op(NFH_OP_CMD, LD_C, 1'b0, 1'b0, q);
            do_op(NFH_OP_ADDR, col, 1'b0, 1'b0, q);
            for (i = 0; i < 6; i++) begin
                exp_b[i] = rnd();
                do_op(NFH_OP_WR, exp_b[i], i == 5, 1'b0, q);
            end
            do_op(NFH_OP_CMD, RD_C, 1'b0, 1'b0, q);
            do_op(NFH_OP_ADDR, col, 1'b0, 1'b0, q);
            repeat (12) @(negedge clk);
            check(ready_seen, 1'b0);
            wait_seen(1'b1, 300);
            for (i = 0; i < 6; i++) begin
                do_op(NFH_OP_RD, 8'h00, i == 5, 1'b0, q);
                check(q, {8'h00, exp_b[i]});
            end
            $display("readback round %0d done", r);
        end
        do_op(NFH_OP_CMD, PG_C, 1'b1, 1'b1, q);
        repeat (12) @(negedge clk);
        check(ready_seen, 1'b1);
        check(wp_n, 1'b0);
        do_op(NFH_OP_CMD, PG_C, 1'b1, 1'b0, q);
        repeat (12) @(negedge clk);
        check(ready_seen, 1'b0);
        check(cs_n, 1'b1);
        wait_seen(1'b1, 300);
        $display("program protect test done");
        test_done();
    end
    initial begin
        #200000;
        err_total++;
        test_done();
    end
endmodule
